// [rtl/dtc_pkg.sv]
// Shared constants for the dual timer/counter with external interrupt flags
package dtc_pkg;

    // Special function register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_PINS = 4'hF;

    // Control register bit positions
    localparam int BIT_T1_OVF = 7;
    localparam int BIT_T1_RUN = 6;
    localparam int BIT_T0_OVF = 5;
    localparam int BIT_T0_RUN = 4;
    localparam int BIT_X1_FLAG = 3;
    localparam int BIT_X1_EDGE = 2;
    localparam int BIT_X0_FLAG = 1;
    localparam int BIT_X0_EDGE = 0;

    // Mode register bit positions
    localparam int BIT_T1_GATE = 7;
    localparam int BIT_T1_CNT = 6;
    localparam int BIT_T1_MODE = 4;
    localparam int BIT_T0_GATE = 3;
    localparam int BIT_T0_CNT = 2;
    localparam int BIT_T0_MODE = 0;

    // Mode field encodings
    localparam logic [1:0] MODE_PRESCALE = 2'h0;
    localparam logic [1:0] MODE_CASCADE = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Synchronised pin indices
    localparam int PIN_COUNT = 4;
    localparam int PIN_T0 = 0;
    localparam int PIN_T1 = 1;
    localparam int PIN_X0 = 2;
    localparam int PIN_X1 = 3;

    // Core clocks per machine cycle, and last count of the divider
    localparam logic [3:0] MC_DIV = 4'hC;
    localparam logic [3:0] MC_LAST = MC_DIV - 4'h1;

    // Prescaler width in the 13-bit mode
    localparam int PRE_BITS = 5;

endpackage

// [rtl/dtc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser with agreement filter and falling-edge pulse
module dtc_pin_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Raw pins
    input wire logic [dtc_pkg::PIN_COUNT-1:0] pin_i,
    // Filtered level and falling-edge pulse
    output logic [dtc_pkg::PIN_COUNT-1:0] level_o,
    output logic [dtc_pkg::PIN_COUNT-1:0] fall_o
);

    // Whole state of the synchroniser
    typedef struct packed {
        logic [dtc_pkg::PIN_COUNT-1:0] s1;
        logic [dtc_pkg::PIN_COUNT-1:0] s2;
        logic [dtc_pkg::PIN_COUNT-1:0] s3;
        logic [dtc_pkg::PIN_COUNT-1:0] lvl;
        logic [dtc_pkg::PIN_COUNT-1:0] fall;
    } dtc_sync_state_t;

    dtc_sync_state_t q; // Current state
    dtc_sync_state_t d; // Next state

    // Stage shift; level changes only when stages two and three agree
    always_comb
    begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
        d.fall = q.lvl & ~d.lvl;
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            q <= '{s1: dtc_pkg::RST_PINS, s2: dtc_pkg::RST_PINS, s3: dtc_pkg::RST_PINS,
                   lvl: dtc_pkg::RST_PINS, fall: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
    assign fall_o = q.fall;

endmodule
`default_nettype wire

// [rtl/dtc_mc_tick.sv]
`timescale 1ns/1ps
`default_nettype none
// Machine-cycle tick: one pulse every MC_DIV core clocks
module dtc_mc_tick (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Tick pulse
    output logic tick_o
);

    // Whole state of the divider
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } dtc_tick_state_t;

    dtc_tick_state_t q; // Current state
    dtc_tick_state_t d; // Next state

    // Wrap counter and tick on last count
    always_comb
    begin
        d = q;
        d.tick = (q.cnt == dtc_pkg::MC_LAST);
        d.cnt = d.tick ? 4'h0 : q.cnt + 4'h1;
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            q <= '{cnt: 4'h0, tick: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule
`default_nettype wire

// [rtl/dtc_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - Two byte registers per timer, split or joined
// RULE_02 - Overflow sets flag; vector acknowledge clears it
// RULE_03 - Run bit written by software starts/stops
// RULE_04 - External flag set by falling edge or level
// RULE_05 - Edge flag cleared on vector; level follows pin
// RULE_06 - Trigger type bit: one edge, zero level
// RULE_07 - External interrupt bits never affect timers
// RULE_08 - Mode 0: 13-bit count, five-bit prescaler
// RULE_09 - Rollover to zero sets overflow flag
// RULE_10 - Count while run and (not gated or pin high)
// RULE_11 - Setting run does not clear counts
// RULE_12 - Mode 1: full 16-bit cascade
// RULE_13 - Mode 2: low byte reloads from high
// RULE_14 - Second timer in mode 3 holds count
// RULE_15 - First timer mode 3 splits into two
// RULE_16 - Split: second timer runs by mode, no flag
// RULE_17 - Both timers share mode behaviour
// RULE_18 - Two-bit mode field selects operation
// RULE_19 - Counter select and gating bit per timer
// RULE_20 - Timer counts machine cycles, counter pin falls
// RULE_21 - Software count writes beat hardware updates
module dtc_timer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // Vector acknowledges from the interrupt controller
    input wire logic timer0_irq_ack_i,
    input wire logic timer1_irq_ack_i,
    input wire logic ext_irq0_ack_i,
    input wire logic ext_irq1_ack_i,
    // External pins
    input wire logic timer0_count_pin_i,
    input wire logic timer1_count_pin_i,
    input wire logic ext_irq0_pin_n_i,
    input wire logic ext_irq1_pin_n_i,
    // Interrupt request flags
    output logic timer0_overflow_flag_o,
    output logic timer1_overflow_flag_o,
    output logic ext_irq0_flag_o,
    output logic ext_irq1_flag_o,
    // Second timer overflow pulse for baud generation
    output logic timer1_baud_tick_o
);

    // Whole state of the block
    typedef struct packed {
        // Count bytes of both timers
        logic [7:0] t0_low;
        logic [7:0] t0_high;
        logic [7:0] t1_low;
        logic [7:0] t1_high;
        // Configuration and control
        logic [7:0] mode_cfg;
        logic [7:0] ctrl;
        // Registered outputs
        logic [7:0] rdata;
        logic baud;
    } dtc_state_t;

    dtc_state_t q; // Current state
    dtc_state_t d; // Next state

    // Outputs of the two helper modules
    logic mc_tick; // Machine-cycle pulse
    logic [dtc_pkg::PIN_COUNT-1:0] pin_lvl; // Filtered pin levels
    logic [dtc_pkg::PIN_COUNT-1:0] pin_fall; // Filtered falling edges

    // Timer working signals
    logic [1:0] mode0; // First timer mode
    logic [1:0] mode1; // Second timer mode
    logic split; // First timer split into two bytes
    logic ev0; // First timer count event
    logic ev1; // Second timer count event
    logic en0; // First timer advances
    logic en1; // Second timer advances
    logic run1; // Second timer run condition
    logic en_hi; // Split high byte advances
    logic [16:0] step0; // First timer stepped value
    logic [16:0] step1; // Second timer stepped value
    logic [8:0] hi_sum; // Split high byte sum
    logic set_tf0; // First overflow event
    logic set_tf1; // Second overflow flag event
    // Working byte for the control register
    logic [7:0] ctrl_base; // Control byte after software write

    // Machine-cycle divider
    // Ticks once every twelve core clocks
    dtc_mc_tick u_tick (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_o(mc_tick)
    );

    // Pin synchronisers
    // Pins pass three flip-flops before any use
    // Packed order: line one, line zero, count pins
    dtc_pin_sync u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i({ext_irq1_pin_n_i, ext_irq0_pin_n_i, timer1_count_pin_i, timer0_count_pin_i}),
        .level_o(pin_lvl),
        .fall_o(pin_fall)
    );

    // One increment of a timer pair in a given mode; returns {overflow, high, low}
    // Used for both timers so the modes stay identical
    function automatic logic [16:0] dtc_step(
        input logic [1:0] mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        // Prescaler with carry-out bit
        logic [5:0] pre;
        // Low byte with carry-out bit
        logic [8:0] sum_lo;
        // High byte with carry-out bit
        logic [8:0] sum_hi;
        // Packed result: overflow, high, low
        logic [16:0] res;

        // Clear locals so every path assigns them
        pre = '0;
        sum_lo = '0;
        sum_hi = '0;
        res = '0;

        // Behaviour per two-bit mode field
        case (mode) // RULE_18
            dtc_pkg::MODE_PRESCALE:
            begin
                // Five-bit prescaler carries into high byte
                pre = {1'b0, lo[dtc_pkg::PRE_BITS-1:0]} + 6'h01; // RULE_08
                sum_hi = {1'b0, hi} + {8'h00, pre[dtc_pkg::PRE_BITS]};
                res = {sum_hi, lo[7:dtc_pkg::PRE_BITS], pre[dtc_pkg::PRE_BITS-1:0]};
            end

            dtc_pkg::MODE_CASCADE:
            begin
                // Full 16-bit cascade
                sum_lo = {1'b0, lo} + 9'h001; // RULE_12
                sum_hi = {1'b0, hi} + {8'h00, sum_lo[8]};
                res = {sum_hi, sum_lo[7:0]};
            end

            dtc_pkg::MODE_RELOAD:
            begin
                // Low byte reloads from high byte on overflow
                sum_lo = {1'b0, lo} + 9'h001;
                res = {sum_lo[8], hi, sum_lo[8] ? hi : sum_lo[7:0]}; // RULE_13
            end

            default:
            begin
                // Split mode: low byte only, high untouched
                sum_lo = {1'b0, lo} + 9'h001;
                res = {sum_lo[8], hi, sum_lo[7:0]};
            end
        endcase

        // Caller picks which parts to keep
        return res;
    endfunction

    // Timer enables and stepping
    always_comb
    begin
        // Mode fields of both timers
        mode0 = q.mode_cfg[dtc_pkg::BIT_T0_MODE +: 2];
        mode1 = q.mode_cfg[dtc_pkg::BIT_T1_MODE +: 2];
        // First timer in mode 3 splits into two bytes
        split = (mode0 == dtc_pkg::MODE_SPLIT);

        // Event source: machine cycle or counter-pin fall
        ev0 = q.mode_cfg[dtc_pkg::BIT_T0_CNT] ? pin_fall[dtc_pkg::PIN_T0] : mc_tick; // RULE_19
        ev1 = q.mode_cfg[dtc_pkg::BIT_T1_CNT] ? pin_fall[dtc_pkg::PIN_T1] : mc_tick; // RULE_20

        // Run and gating qualify the event; interrupt flag bits play no part
        en0 = q.ctrl[dtc_pkg::BIT_T0_RUN] & ev0 // RULE_10
            & (~q.mode_cfg[dtc_pkg::BIT_T0_GATE] | pin_lvl[dtc_pkg::PIN_X0]); // RULE_07

        // In split mode the run bit belongs to the first timer's high byte
        run1 = split ? 1'b1 : q.ctrl[dtc_pkg::BIT_T1_RUN]; // RULE_16
        en1 = run1 & ev1 & (mode1 != dtc_pkg::MODE_SPLIT) // RULE_14
            & (~q.mode_cfg[dtc_pkg::BIT_T1_GATE] | pin_lvl[dtc_pkg::PIN_X1]);

        // Split high byte counts machine cycles under the second run bit
        en_hi = split & q.ctrl[dtc_pkg::BIT_T1_RUN] & mc_tick; // RULE_15

        // Both pairs share one stepping function
        step0 = dtc_step(mode0, q.t0_low, q.t0_high); // RULE_17
        step1 = dtc_step(mode1, q.t1_low, q.t1_high);

        // Split high byte has its own adder
        hi_sum = {1'b0, q.t0_high} + 9'h001;

        // Overflow events; second flag from high byte when split
        set_tf0 = en0 & step0[16]; // RULE_09
        set_tf1 = split ? (en_hi & hi_sum[8]) : (en1 & step1[16]);
    end

    // Next-state logic for counts, control and read data
    always_comb
    begin
        d = q;

        // Hardware counting leaves counts alone unless enabled
        if (en0) // RULE_11
        begin
            d.t0_low = step0[7:0]; // RULE_01
            d.t0_high = step0[15:8];
        end

        // Split high byte advance overrides the stepped value
        if (en_hi)
        begin
            d.t0_high = hi_sum[7:0];
        end

        // Second timer pair
        if (en1)
        begin
            d.t1_low = step1[7:0];
            d.t1_high = step1[15:8];
        end

        // Baud pulse on each second-timer wrap, split or not
        d.baud = en1 & step1[16];

        // Software writes to count registers win
        if (sfr_wr_i)
        begin
            unique case (sfr_addr_i)
                dtc_pkg::ADDR_T0_LOW: d.t0_low = sfr_wdata_i; // RULE_21
                dtc_pkg::ADDR_T0_HIGH: d.t0_high = sfr_wdata_i;
                dtc_pkg::ADDR_T1_LOW: d.t1_low = sfr_wdata_i;
                dtc_pkg::ADDR_T1_HIGH: d.t1_high = sfr_wdata_i;
                dtc_pkg::ADDR_MODE: d.mode_cfg = sfr_wdata_i;
                default:
                begin
                    // Control byte handled below; others ignored
                end
            endcase
        end

        // Control byte: software write, then acknowledge clears, then sets
        ctrl_base = (sfr_wr_i && sfr_addr_i == dtc_pkg::ADDR_CTRL) ? sfr_wdata_i : q.ctrl; // RULE_03
        // Vector acknowledges clear the overflow flags
        if (timer0_irq_ack_i)
        begin
            ctrl_base[dtc_pkg::BIT_T0_OVF] = 1'b0; // RULE_02
        end
        if (timer1_irq_ack_i)
        begin
            ctrl_base[dtc_pkg::BIT_T1_OVF] = 1'b0;
        end

        // Acknowledge clears external flags only in edge mode
        if (ext_irq0_ack_i && q.ctrl[dtc_pkg::BIT_X0_EDGE])
        begin
            ctrl_base[dtc_pkg::BIT_X0_FLAG] = 1'b0; // RULE_05
        end
        if (ext_irq1_ack_i && q.ctrl[dtc_pkg::BIT_X1_EDGE])
        begin
            ctrl_base[dtc_pkg::BIT_X1_FLAG] = 1'b0;
        end

        // Hardware sets win over any clear in the same cycle
        ctrl_base[dtc_pkg::BIT_T0_OVF] = ctrl_base[dtc_pkg::BIT_T0_OVF] | set_tf0;
        ctrl_base[dtc_pkg::BIT_T1_OVF] = ctrl_base[dtc_pkg::BIT_T1_OVF] | set_tf1;

        // External flags: edge mode latches falls, level mode tracks pin
        if (q.ctrl[dtc_pkg::BIT_X0_EDGE]) // RULE_06
        begin
            ctrl_base[dtc_pkg::BIT_X0_FLAG] = ctrl_base[dtc_pkg::BIT_X0_FLAG]
                | pin_fall[dtc_pkg::PIN_X0]; // RULE_04
        end
        else
        begin
            ctrl_base[dtc_pkg::BIT_X0_FLAG] = ~pin_lvl[dtc_pkg::PIN_X0]; // RULE_05
        end

        // Same handling for line one
        if (q.ctrl[dtc_pkg::BIT_X1_EDGE])
        begin
            ctrl_base[dtc_pkg::BIT_X1_FLAG] = ctrl_base[dtc_pkg::BIT_X1_FLAG]
                | pin_fall[dtc_pkg::PIN_X1]; // RULE_04
        end
        else
        begin
            ctrl_base[dtc_pkg::BIT_X1_FLAG] = ~pin_lvl[dtc_pkg::PIN_X1];
        end

        d.ctrl = ctrl_base;

        // Registered read data, unmapped addresses read zero
        unique case (sfr_addr_i)
            dtc_pkg::ADDR_CTRL: d.rdata = q.ctrl;
            dtc_pkg::ADDR_MODE: d.rdata = q.mode_cfg;
            dtc_pkg::ADDR_T0_LOW: d.rdata = q.t0_low;
            dtc_pkg::ADDR_T0_HIGH: d.rdata = q.t0_high;
            dtc_pkg::ADDR_T1_LOW: d.rdata = q.t1_low;
            dtc_pkg::ADDR_T1_HIGH: d.rdata = q.t1_high;
            default: d.rdata = dtc_pkg::RST_BYTE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            // Counts, configuration and flags all zero
            q <= '{t0_low: dtc_pkg::RST_BYTE, t0_high: dtc_pkg::RST_BYTE,
                   t1_low: dtc_pkg::RST_BYTE, t1_high: dtc_pkg::RST_BYTE,
                   mode_cfg: dtc_pkg::RST_BYTE, ctrl: dtc_pkg::RST_BYTE,
                   rdata: dtc_pkg::RST_BYTE, baud: 1'b0};
        end
        else
        begin
            // Normal operation takes the next state
            q <= d;
        end
    end

    // Outputs from registers
    // Read data and baud pulse come straight from flip-flops
    assign sfr_rdata_o = q.rdata;
    // Flag outputs mirror the control byte bits
    assign timer0_overflow_flag_o = q.ctrl[dtc_pkg::BIT_T0_OVF];
    assign timer1_overflow_flag_o = q.ctrl[dtc_pkg::BIT_T1_OVF];
    assign ext_irq0_flag_o = q.ctrl[dtc_pkg::BIT_X0_FLAG];
    assign ext_irq1_flag_o = q.ctrl[dtc_pkg::BIT_X1_FLAG];
    assign timer1_baud_tick_o = q.baud;

endmodule
`default_nettype wire

// [tb/dtc_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checks for the timer block
module dtc_timer_checker (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // Acknowledges and pins
    input wire logic timer0_irq_ack_i,
    input wire logic ext_irq0_ack_i,
    input wire logic ext_irq0_pin_n_i,
    input wire logic ext_irq1_pin_n_i,
    // Flags
    input wire logic timer0_overflow_flag_o,
    input wire logic timer1_overflow_flag_o,
    input wire logic ext_irq0_flag_o,
    input wire logic ext_irq1_flag_o,
    input wire logic timer1_baud_tick_o
);
    // Control write strobe
    logic ctl_wr;
    // Shadow of software control bits
    logic [7:0] ctl_q;
    assign ctl_wr = sfr_wr_i && sfr_addr_i == dtc_pkg::ADDR_CTRL;
    // Track control writes
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ctl_q <= 8'h00;
        else if (ctl_wr)
            ctl_q <= sfr_wdata_i;
    end
    default clocking dcb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_mode_rw;
        sfr_wr_i && sfr_addr_i == dtc_pkg::ADDR_MODE ##1 sfr_addr_i == dtc_pkg::ADDR_MODE
            && !sfr_wr_i |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
    endproperty
    a_mode_rw: assert property (p_mode_rw) else $error("mode readback wrong");
    property p_unmapped;
        !(sfr_addr_i inside {[8'h88:8'h8D]}) |=> sfr_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mirror;
        sfr_addr_i == dtc_pkg::ADDR_CTRL |=> {sfr_rdata_o[7], sfr_rdata_o[5], sfr_rdata_o[3],
            sfr_rdata_o[1]} == $past({timer1_overflow_flag_o, timer0_overflow_flag_o,
            ext_irq1_flag_o, ext_irq0_flag_o});
    endproperty
    a_mirror: assert property (p_mirror) else $error("flag bits misplaced");
    property p_level_set;
        (!ctl_q[0] && !ext_irq0_pin_n_i) [*8] |-> ext_irq0_flag_o;
    endproperty
    a_level_set: assert property (p_level_set) else $error("level flag not set");
    property p_level_clr;
        (!ctl_q[2] && ext_irq1_pin_n_i) [*8] |-> !ext_irq1_flag_o;
    endproperty
    a_level_clr: assert property (p_level_clr) else $error("level flag stuck");
    property p_edge_ack;
        ext_irq0_pin_n_i [*8] ##0 (ctl_q[0] && (ext_irq0_ack_i || !ext_irq0_flag_o) && !ctl_wr)
            |=> !ext_irq0_flag_o;
    endproperty
    a_edge_ack: assert property (p_edge_ack) else $error("edge flag not cleared");
    property p_t0_ack;
        timer0_irq_ack_i && !ctl_wr && !ctl_q[4] && !$past(ctl_q[4]) |=> !timer0_overflow_flag_o;
    endproperty
    a_t0_ack: assert property (p_t0_ack) else $error("overflow flag not cleared");
    property p_baud;
        timer1_baud_tick_o |=> !timer1_baud_tick_o;
    endproperty
    a_baud: assert property (p_baud) else $error("baud pulse too long");
endmodule
bind dtc_timer dtc_timer_checker i_dtc_timer_checker (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .timer0_irq_ack_i(timer0_irq_ack_i),
    .ext_irq0_ack_i(ext_irq0_ack_i),
    .ext_irq0_pin_n_i(ext_irq0_pin_n_i),
    .ext_irq1_pin_n_i(ext_irq1_pin_n_i),
    .timer0_overflow_flag_o(timer0_overflow_flag_o),
    .timer1_overflow_flag_o(timer1_overflow_flag_o),
    .ext_irq0_flag_o(ext_irq0_flag_o),
    .ext_irq1_flag_o(ext_irq1_flag_o),
    .timer1_baud_tick_o(timer1_baud_tick_o)
);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the timer block
module testbench;
    // Stimulus and responses
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [3:0] ack = 4'h0;
    logic cnt0 = 1'b1;
    logic [1:0] irq_n = 2'h3;
    logic [3:0] flags;
    logic baud;
    int err_count = 0;
    int comparisons = 0;
    // Device under test; flags and acks ordered t1, t0, x1, x0
    dtc_timer i_dtc_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .sfr_addr_i(addr),
        .sfr_wr_i(wr),
        .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata),
        .timer0_irq_ack_i(ack[2]),
        .timer1_irq_ack_i(ack[3]),
        .ext_irq0_ack_i(ack[0]),
        .ext_irq1_ack_i(ack[1]),
        .timer0_count_pin_i(cnt0),
        .timer1_count_pin_i(1'b1),
        .ext_irq0_pin_n_i(irq_n[0]),
        .ext_irq1_pin_n_i(irq_n[1]),
        .timer0_overflow_flag_o(flags[2]),
        .timer1_overflow_flag_o(flags[3]),
        .ext_irq0_flag_o(flags[0]),
        .ext_irq1_flag_o(flags[1]),
        .timer1_baud_tick_o(baud)
    );
    // Core clock, 10 ns
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    // Idle cycles
    task automatic ticks(input int n);
    begin
        repeat (n) @(negedge mclk_i);
    end
    endtask
    // One-cycle register write
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(negedge mclk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    end
    endtask
    // Register read, data one cycle after the address
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    begin
        @(negedge mclk_i);
        addr = a;
        @(negedge mclk_i);
        chk(rdata, exp);
    end
    endtask
    // Vector acknowledge pulse
    task automatic ackp(input int i);
    begin
        @(negedge mclk_i);
        ack[i] = 1'b1;
        @(negedge mclk_i);
        ack[i] = 1'b0;
    end
    endtask
    // Single flag check
    task automatic chf(input int i, input logic v);
    begin
        chk({7'h00, flags[i]}, {7'h00, v});
    end
    endtask
    // Bounded wait for a flag
    task automatic wait_flag(input int i);
        int n;
    begin
        n = 0;
        while (flags[i] !== 1'b1 && n < 300)
        begin
            @(negedge mclk_i);
            n++;
        end
        chf(i, 1'b1);
        if (n >= 300)
            report_and_stop();
    end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
    begin
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        ticks(12);
        rst_i = 1'b0;
        // Reset values and one unmapped slot
        for (int a = 8'h88; a <= 8'h8E; a++)
            rdc(a[7:0], 8'h00);
        // Sixteen-bit wrap of timer 0
        wrr(dtc_pkg::ADDR_T0_LOW, 8'hFF);
        wrr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
        wrr(dtc_pkg::ADDR_MODE, 8'h01);
        rdc(dtc_pkg::ADDR_MODE, 8'h01);
        wrr(dtc_pkg::ADDR_CTRL, 8'h10);
        wait_flag(2);
        rdc(dtc_pkg::ADDR_T0_HIGH, 8'h00);
        ackp(2);
        chf(2, 1'b0);
        // Thirteen-bit wrap keeps the top three low bits
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        wrr(dtc_pkg::ADDR_T0_LOW, 8'hFF);
        wrr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
        wrr(dtc_pkg::ADDR_MODE, 8'h00);
        wrr(dtc_pkg::ADDR_CTRL, 8'h10);
        wait_flag(2);
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        rdc(dtc_pkg::ADDR_T0_LOW, 8'hE0);
        rdc(dtc_pkg::ADDR_T0_HIGH, 8'h00);
        // Timer 1 autoreload
        wrr(dtc_pkg::ADDR_T1_HIGH, 8'hA0);
        wrr(dtc_pkg::ADDR_T1_LOW, 8'hFE);
        wrr(dtc_pkg::ADDR_MODE, 8'h20);
        wrr(dtc_pkg::ADDR_CTRL, 8'h40);
        wait_flag(3);
        chk({7'h00, baud}, 8'h01);
        rdc(dtc_pkg::ADDR_T1_LOW, 8'hA0);
        rdc(dtc_pkg::ADDR_T1_HIGH, 8'hA0);
        ackp(3);
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        // Gated count with level flag on line 0
        wrr(dtc_pkg::ADDR_T0_LOW, 8'h00);
        wrr(dtc_pkg::ADDR_MODE, 8'h09);
        irq_n[0] = 1'b0;
        wrr(dtc_pkg::ADDR_CTRL, 8'h10);
        ticks(40);
        chf(0, 1'b1);
        rdc(dtc_pkg::ADDR_T0_LOW, 8'h00);
        irq_n[0] = 1'b1;
        ticks(60);
        chf(0, 1'b0);
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        @(negedge mclk_i);
        addr = dtc_pkg::ADDR_T0_LOW;
        @(negedge mclk_i);
        chk({7'h00, rdata inside {8'h04, 8'h05}}, 8'h01);
        // Counter function on pin falls
        wrr(dtc_pkg::ADDR_T0_LOW, 8'h00);
        wrr(dtc_pkg::ADDR_MODE, 8'h05);
        wrr(dtc_pkg::ADDR_CTRL, 8'h10);
        repeat (3)
        begin
            cnt0 = 1'b0;
            ticks(6);
            cnt0 = 1'b1;
            ticks(6);
        end
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        rdc(dtc_pkg::ADDR_T0_LOW, 8'h03);
        // Edge-triggered line 0
        wrr(dtc_pkg::ADDR_CTRL, 8'h01);
        irq_n[0] = 1'b0;
        ticks(10);
        chf(0, 1'b1);
        irq_n[0] = 1'b1;
        ticks(10);
        chf(0, 1'b1);
        ackp(0);
        chf(0, 1'b0);
        // Level-triggered line 1 ignores the acknowledge
        irq_n[1] = 1'b0;
        ticks(10);
        chf(1, 1'b1);
        ackp(1);
        chf(1, 1'b1);
        irq_n[1] = 1'b1;
        ticks(10);
        chf(1, 1'b0);
        // Split timer 0, high byte on timer 1 run bit
        wrr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
        wrr(dtc_pkg::ADDR_MODE, 8'h03);
        wrr(dtc_pkg::ADDR_CTRL, 8'h40);
        wait_flag(3);
        chf(2, 1'b0);
        rdc(dtc_pkg::ADDR_T0_HIGH, 8'h00);
        ackp(3);
        // Timer 1 in mode 3 holds
        wrr(dtc_pkg::ADDR_MODE, 8'h30);
        wrr(dtc_pkg::ADDR_T1_LOW, 8'h05);
        ticks(40);
        rdc(dtc_pkg::ADDR_T1_LOW, 8'h05);
        wrr(dtc_pkg::ADDR_CTRL, 8'h00);
        ticks(2);
        ackp(2);
        report_and_stop();
    end
endmodule
`default_nettype wire
